// ### logic/refsel_top.sv
// speed reference and control location selector with APB registers
//
// Functional notes
// - panel unit: 1 means Hz, 2 percent
// - digital input low selects one, high two
// - setting 6 fixes location one
// - setting 7 fixes location two
// - setting 8 follows serial master's choice
// - mode 11: input three up, four down
// - mode 11: stop clears up/down reference
// - each location keeps its own up/down value
// - mode 12: up/down three/four, no clear
// - third mode: input five lowers speed
// - reference one equals lower limit at minimum
// - reference one equals upper limit at maximum
// - reference two offers same source set
// - reference two spans its percent limits
// - macro flag chooses process or frequency limits; here control bit CTRL_PROCESS_BIT only raises ref_is_process at location two
//
// Our own choices: the APB register port and the register addresses.
`include "refsel_map.svh"
`timescale 1ns/10ps
module refsel_top #(
   parameter int UPDOWN_TICK = `UPDOWN_TICK_CYCLES
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                srst,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // drive inputs
   input  wire logic [4:0]          digital_in,
   input  wire refsel_pkg::ref_word_t analog_one,
   input  wire refsel_pkg::ref_word_t analog_two,
   input  wire logic [1:0]          cmd_one,
   input  wire logic [1:0]          cmd_two,
   input  wire logic [1:0]          cmd_panel,
   input  wire refsel_pkg::ref_word_t panel_ref,
   // drive outputs
   output refsel_pkg::ref_word_t    speed_ref,
   output logic                     ref_is_percent,
   output logic                     ref_is_process,
   output logic [1:0]               active_cmd,
   output refsel_pkg::location_t    active_location
);
   import refsel_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [3:0] panel_reference_unit_select_r;
   logic [3:0] external_location_select_r;
   logic [3:0] ref_one_source_select_r;
   logic [3:0] ref_two_source_select_r;
   ref_word_t  ref_one_lower_limit_r;
   ref_word_t  ref_one_upper_limit_r;
   ref_word_t  ref_two_lower_limit_r;
   ref_word_t  ref_two_upper_limit_r;
   ref_word_t  step_r;
   logic [3:0] control_r;

   wire logic wr_en;
   wire logic rd_en;
   wire logic addr_ok;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `REG_UPDOWN_STEP);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // one decoded strobe per writable register; refused addresses hit none of them
   wire logic wr_panel_unit;
   wire logic wr_loc_select;
   wire logic wr_one_source;
   wire logic wr_one_lower;
   wire logic wr_one_upper;
   wire logic wr_two_source;
   wire logic wr_two_lower;
   wire logic wr_two_upper;
   wire logic wr_control;
   wire logic wr_step;
   assign wr_panel_unit = wr_en && (paddr == `REG_PANEL_UNIT);
   assign wr_loc_select = wr_en && (paddr == `REG_LOC_SELECT);
   assign wr_one_source = wr_en && (paddr == `REG_ONE_SOURCE);
   assign wr_one_lower  = wr_en && (paddr == `REG_ONE_LOWER);
   assign wr_one_upper  = wr_en && (paddr == `REG_ONE_UPPER);
   assign wr_two_source = wr_en && (paddr == `REG_TWO_SOURCE);
   assign wr_two_lower  = wr_en && (paddr == `REG_TWO_LOWER);
   assign wr_two_upper  = wr_en && (paddr == `REG_TWO_UPPER);
   assign wr_control    = wr_en && (paddr == `REG_CONTROL);
   assign wr_step       = wr_en && (paddr == `REG_UPDOWN_STEP);

   always_ff @(posedge clk) begin
      if (srst) begin
         panel_reference_unit_select_r <= `RST_PANEL_UNIT;
         external_location_select_r    <= `RST_LOC_SELECT;
         ref_one_source_select_r       <= `RST_SOURCE;
         ref_two_source_select_r       <= `RST_SOURCE;
         ref_one_lower_limit_r         <= `RST_LOWER;
         ref_one_upper_limit_r         <= `RST_UPPER;
         ref_two_lower_limit_r         <= `RST_LOWER;
         ref_two_upper_limit_r         <= `RST_UPPER;
         step_r                        <= `RST_STEP;
         control_r                     <= 4'h0;
      end else begin
         if (wr_panel_unit) begin
            panel_reference_unit_select_r <= pwdata[3:0];
         end
         if (wr_loc_select) begin
            external_location_select_r <= pwdata[3:0];
         end
         if (wr_one_source) begin
            ref_one_source_select_r <= pwdata[3:0];
         end
         if (wr_two_source) begin
            ref_two_source_select_r <= pwdata[3:0];
         end
         if (wr_one_lower) begin
            ref_one_lower_limit_r <= pwdata[15:0];
         end
         if (wr_one_upper) begin
            ref_one_upper_limit_r <= pwdata[15:0];
         end
         if (wr_two_lower) begin
            ref_two_lower_limit_r <= pwdata[15:0];
         end
         if (wr_two_upper) begin
            ref_two_upper_limit_r <= pwdata[15:0];
         end
         if (wr_control) begin
            control_r <= pwdata[3:0];
         end
         if (wr_step) begin
            step_r <= pwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // location selection
   wire logic local_mode;
   wire logic serial_two;
   wire logic sel_two;
   wire logic [2:0] di_index;
   assign local_mode = control_r[`CTRL_LOCAL_BIT];
   assign serial_two = control_r[`CTRL_SERIAL_TWO_BIT];
   assign di_index   = external_location_select_r[2:0] - 3'h1;
   // codes outside 1..8 fall back to location one
   assign sel_two =
      (external_location_select_r >= 4'h1 && external_location_select_r <= `LOC_SEL_DI_LAST)
         ? digital_in[di_index]
      : (external_location_select_r == `LOC_SEL_FIX_TWO) ? 1'b1
      : (external_location_select_r == `LOC_SEL_SERIAL) ? serial_two
      : 1'b0;

   location_t loc_nxt;
   assign loc_nxt = local_mode ? LOC_PANEL : (sel_two ? LOC_TWO : LOC_ONE);

   ////////////////////////////////////////////////////////////////////////////
   // up/down reference, one memory per location
   logic [14:0] tick_cnt_r;
   wire  logic  tick;
   assign tick = (tick_cnt_r == 15'(UPDOWN_TICK - 1));
   always_ff @(posedge clk) begin
      if (srst || tick) begin
         tick_cnt_r <= 15'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_r + 15'h0001;
      end
   end

   wire logic [3:0] cur_src;
   wire logic       stop_now;
   wire logic [1:0] loc_cmd;
   wire logic       is_updown;
   wire logic       up_in;
   wire logic       down_in;
   assign cur_src   = sel_two ? ref_two_source_select_r : ref_one_source_select_r;
   // stop comes from the selected location's own command, not the registered one:
   // the old command would clear the new location's memory on a switch
   assign loc_cmd   = sel_two ? cmd_two : cmd_one;
   assign stop_now  = control_r[`CTRL_STOP_BIT] | (loc_cmd == 2'h0);
   assign is_updown = (cur_src == `SRC_UPDOWN_CLR) || (cur_src == `SRC_UPDOWN_34) ||
                      (cur_src == `SRC_UPDOWN_35);
   assign up_in     = digital_in[2];
   assign down_in   = (cur_src == `SRC_UPDOWN_35) ? digital_in[4]
                                                  : digital_in[3];

   ref_word_t updown_mem_r [2];
   ref_word_t cur_mem;
   ref_word_t mem_nxt;
   wire logic [16:0] up_sum;
   assign cur_mem = updown_mem_r[sel_two];
   assign up_sum  = {1'b0, cur_mem} + {1'b0, step_r};
   always_comb begin
      mem_nxt = cur_mem;
      if ((cur_src == `SRC_UPDOWN_CLR) && stop_now) begin
         mem_nxt = 16'h0000;
      end else if (tick && up_in && !down_in) begin
         mem_nxt = up_sum[16] ? 16'hFFFF : up_sum[15:0];
      end else if (tick && down_in && !up_in) begin
         mem_nxt = (cur_mem > step_r) ? cur_mem - step_r : 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         updown_mem_r[0] <= 16'h0000;
         updown_mem_r[1] <= 16'h0000;
      end else if (is_updown && !local_mode) begin
         updown_mem_r[sel_two] <= mem_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog scaling of both external references
   ref_scale_if sc_one ();
   ref_scale_if sc_two ();
   assign sc_one.analog_in   = analog_one;
   assign sc_one.lower_limit = ref_one_lower_limit_r;
   assign sc_one.upper_limit = ref_one_upper_limit_r;
   assign sc_two.analog_in   = analog_two;
   assign sc_two.lower_limit = ref_two_lower_limit_r;
   assign sc_two.upper_limit = ref_two_upper_limit_r;

   ref_scaler u_scale_one (
      .clk  (clk),
      .srst (srst),
      .sc   (sc_one.scaler)
   );
   ref_scaler u_scale_two (
      .clk  (clk),
      .srst (srst),
      .sc   (sc_two.scaler)
   );

   ////////////////////////////////////////////////////////////////////////////
   // output selection
   ref_word_t ref_nxt;
   logic      pct_nxt;
   logic [1:0] cmd_nxt;
   always_comb begin
      ref_nxt = 16'h0000;
      pct_nxt = 1'b0;
      cmd_nxt = 2'h0;
      case (loc_nxt)
         LOC_PANEL: begin
            ref_nxt = panel_ref;
            pct_nxt = (panel_reference_unit_select_r == `UNIT_PERCENT);
            cmd_nxt = cmd_panel;
         end
         LOC_TWO: begin
            ref_nxt = is_updown ? mem_nxt : sc_two.scaled_ref;
            pct_nxt = 1'b1;
            cmd_nxt = cmd_two;
         end
         default: begin
            ref_nxt = is_updown ? mem_nxt : sc_one.scaled_ref;
            pct_nxt = 1'b0;
            cmd_nxt = cmd_one;
         end
      endcase
   end

   // process flag only matters when reference two carries a percentage
   always_ff @(posedge clk) begin
      if (srst) begin
         speed_ref       <= 16'h0000;
         ref_is_percent  <= 1'b0;
         ref_is_process  <= 1'b0;
         active_cmd      <= 2'h0;
         active_location <= LOC_ONE;
      end else begin
         speed_ref       <= ref_nxt;
         ref_is_percent  <= pct_nxt;
         ref_is_process  <= (loc_nxt == LOC_TWO) & control_r[`CTRL_PROCESS_BIT];
         active_cmd      <= cmd_nxt;
         active_location <= loc_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb read mux
   wire logic [31:0] status_word;
   assign status_word = {27'h0000000, ref_is_process, ref_is_percent, active_location, sel_two};
   always_comb begin
      prdata = 32'h00000000;
      if (rd_en) begin
         case (paddr)
            `REG_PANEL_UNIT:  prdata = {28'h0000000, panel_reference_unit_select_r};
            `REG_LOC_SELECT:  prdata = {28'h0000000, external_location_select_r};
            `REG_ONE_SOURCE:  prdata = {28'h0000000, ref_one_source_select_r};
            `REG_TWO_SOURCE:  prdata = {28'h0000000, ref_two_source_select_r};
            `REG_ONE_LOWER:   prdata = {16'h0000, ref_one_lower_limit_r};
            `REG_ONE_UPPER:   prdata = {16'h0000, ref_one_upper_limit_r};
            `REG_TWO_LOWER:   prdata = {16'h0000, ref_two_lower_limit_r};
            `REG_TWO_UPPER:   prdata = {16'h0000, ref_two_upper_limit_r};
            `REG_CONTROL:     prdata = {28'h0000000, control_r};
            `REG_STATUS:      prdata = status_word;
            `REG_REF_OUT:     prdata = {16'h0000, speed_ref};
            `REG_UPDOWN_STEP: prdata = {16'h0000, step_r};
            default:          prdata = 32'h00000000;
         endcase
      end
   end
endmodule

// ### logic/refsel_map.svh
// register offsets, field codes and reset values of the reference selector
`ifndef REFSEL_MAP_SVH
`define REFSEL_MAP_SVH

`define REG_PANEL_UNIT      12'h000
`define REG_LOC_SELECT      12'h004
`define REG_ONE_SOURCE      12'h008
`define REG_ONE_LOWER       12'h00C
`define REG_ONE_UPPER       12'h010
`define REG_TWO_SOURCE      12'h014
`define REG_TWO_LOWER       12'h018
`define REG_TWO_UPPER       12'h01C
`define REG_CONTROL         12'h020
`define REG_STATUS          12'h024
`define REG_REF_OUT         12'h028
`define REG_UPDOWN_STEP     12'h02C

`define UNIT_HZ             4'h1
`define UNIT_PERCENT        4'h2
`define LOC_SEL_DI_LAST     4'h5
`define LOC_SEL_FIX_ONE     4'h6
`define LOC_SEL_FIX_TWO     4'h7
`define LOC_SEL_SERIAL      4'h8
`define SRC_UPDOWN_CLR      4'hB
`define SRC_UPDOWN_34       4'hC
`define SRC_UPDOWN_35       4'hD

`define CTRL_LOCAL_BIT      0
`define CTRL_PROCESS_BIT    1
`define CTRL_SERIAL_TWO_BIT 2
`define CTRL_STOP_BIT       3

`define RST_PANEL_UNIT      4'h1
`define RST_LOC_SELECT      4'h6
`define RST_SOURCE          4'h1
`define RST_LOWER           16'h0000
`define RST_UPPER           16'h0032
`define RST_STEP            16'h0001
`define UPDOWN_TICK_CYCLES  20000

`endif

// ### logic/refsel_pkg.sv
// types shared by the reference selector modules
package refsel_pkg;
   typedef logic [15:0] ref_word_t;
   typedef enum logic [1:0] {
      LOC_ONE,
      LOC_TWO,
      LOC_PANEL
   } location_t;
endpackage

// ### logic/ref_scale_if.sv
// scaling request carrier between selector and scaler
`timescale 1ns/10ps
interface ref_scale_if;
   logic [15:0] analog_in;
   logic [15:0] lower_limit;
   logic [15:0] upper_limit;
   logic [15:0] scaled_ref;
   modport ctrl (output analog_in, output lower_limit, output upper_limit, input scaled_ref);
   modport scaler (input analog_in, input lower_limit, input upper_limit, output scaled_ref);
endinterface

// ### logic/ref_scaler.sv
// linear mapping of an analog reading onto a programmed reference span
`timescale 1ns/10ps
module ref_scaler (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   srst,
   // scaling port
   ref_scale_if.scaler sc
);
   import refsel_pkg::*;
   // signed span allows an upper limit below the lower one (inverted reference)
   wire logic signed [17:0] span;
   wire logic signed [34:0] prod;
   wire logic signed [34:0] sum;
   assign span = $signed({2'b00, sc.upper_limit}) - $signed({2'b00, sc.lower_limit});
   assign prod = span * $signed({1'b0, sc.analog_in});
   // full-scale reading 16'hFFFF lands exactly on the upper limit
   assign sum  = $signed({19'h00000, sc.lower_limit}) + (prod / 35'sd65535);
   ref_word_t scaled_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         scaled_r <= 16'h0000;
      end else begin
         scaled_r <= sum[15:0];
      end
   end
   assign sc.scaled_ref = scaled_r;
endmodule

// ### tb/field_side.sv
// far side model: digital inputs, analog sensors, command sources and panel
`timescale 1ns/10ps
module field_side (
   // clock
   input  wire logic        clk,
   // levels asked for by the bench
   input  wire logic [4:0]  di_req,
   input  wire logic [15:0] a1_req,
   input  wire logic [15:0] a2_req,
   input  wire logic [5:0]  cmd_req,
   input  wire logic [15:0] pref_req,
   // levels seen by the drive
   output logic [4:0]       digital_in,
   output logic [15:0]      analog_one,
   output logic [15:0]      analog_two,
   output logic [1:0]       cmd_one,
   output logic [1:0]       cmd_two,
   output logic [1:0]       cmd_panel,
   output logic [15:0]      panel_ref
);
   // levels move only just after an edge, like settled field wiring
   always_ff @(posedge clk) begin
      digital_in <= di_req;
      analog_one <= a1_req;
      analog_two <= a2_req;
      cmd_one    <= cmd_req[1:0];
      cmd_two    <= cmd_req[3:2];
      cmd_panel  <= cmd_req[5:4];
      panel_ref  <= pref_req;
   end
endmodule

// ### tb/refsel_top_sva.sv
// port assertions of the reference selector
`timescale 1ns/10ps
module refsel_top_sva
   import refsel_pkg::*;
#(
   parameter int UPDOWN_TICK = 20000
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // drive side
   input wire logic [1:0]  cmd_one,
   input wire logic [1:0]  cmd_two,
   input wire logic [1:0]  cmd_panel,
   input wire ref_word_t   panel_ref,
   input wire ref_word_t   speed_ref,
   input wire logic        ref_is_percent,
   input wire logic        ref_is_process,
   input wire logic [1:0]  active_cmd,
   input wire location_t   active_location
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_ready_zero_wait:
      assert property (psel && penable |-> pready) else $error("pready low in access");
   a_error_unmapped:
      assert property (psel && penable && (paddr > 12'h02C || paddr[1:0] != 2'b00)
         |-> pslverr && prdata == 32'h0) else $error("bad address not refused");
   a_read_idle_zero:
      assert property (!(psel && penable) |-> prdata == 32'h0 && !pslverr)
         else $error("read bus busy outside access");
   a_cmd_loc_one:
      assert property (active_location == LOC_ONE && !$past(srst)
         |-> active_cmd == $past(cmd_one)) else $error("command not from location one");
   a_cmd_loc_two:
      assert property (active_location == LOC_TWO && !$past(srst)
         |-> active_cmd == $past(cmd_two)) else $error("command not from location two");
   a_panel_follow:
      assert property (active_location == LOC_PANEL && !$past(srst)
         |-> active_cmd == $past(cmd_panel) && speed_ref == $past(panel_ref))
         else $error("panel selection not followed");
   a_two_percent:
      assert property (active_location == LOC_TWO |-> ref_is_percent)
         else $error("location two not in percent");
   a_process_two:
      assert property (ref_is_process |-> active_location == LOC_TWO)
         else $error("process flag outside location two");
endmodule
bind refsel_top refsel_top_sva #(.UPDOWN_TICK(UPDOWN_TICK)) u_refsel_top_sva (
   .clk, .srst, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .cmd_one, .cmd_two,
   .cmd_panel, .panel_ref, .speed_ref, .ref_is_percent, .ref_is_process, .active_cmd,
   .active_location);

// ### tb/tb.sv
// self-checking bench of the reference selector
`timescale 1ns/10ps
`include "refsel_map.svh"
module tb;
   import refsel_pkg::*;
   logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
   logic        ref_is_percent, ref_is_process;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0]  di, digital_in;
   logic [5:0]  cmds;
   logic [15:0] a1, a2, pref, analog_one, analog_two, panel_ref;
   logic [1:0]  cmd_one, cmd_two, cmd_panel, active_cmd;
   ref_word_t   speed_ref;
   location_t   active_location;
   logic [15:0] av[3] = '{16'h0000, 16'hFFFF, 16'h8000};
   logic [15:0] ev[2][3] = '{'{16'h000A, 16'h0032, 16'h001E}, '{16'h0005, 16'h0064, 16'h0034}};
   int          failures = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   refsel_top #(.UPDOWN_TICK(4)) u_refsel_top (.clk, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .digital_in, .analog_one, .analog_two, .cmd_one,
      .cmd_two, .cmd_panel, .panel_ref, .speed_ref, .ref_is_percent, .ref_is_process,
      .active_cmd, .active_location);
   field_side u_field_side (.clk, .di_req(di), .a1_req(a1), .a2_req(a2), .cmd_req(cmds),
      .pref_req(pref), .digital_in, .analog_one, .analog_two, .cmd_one, .cmd_two, .cmd_panel,
      .panel_ref);
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; the hang guard below ends a missing pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask
   // holds the buttons for 15 up/down ticks, enough to saturate at this step
   task automatic press(input logic [4:0] v);
      di <= v;
      repeat (60) @(posedge clk);
      di <= 5'h00;
      settle;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop;
      end
   end
   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {di, a1, a2} = '0;
      cmds = 6'h39;
      pref = 16'h0123;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, `REG_PANEL_UNIT, 32'h0);
      check(rd, 32'h1);
      apb(1'b1, 12'h006, 32'h7);
      check(err, 1'b1);
      apb(1'b0, `REG_LOC_SELECT, 32'h0);
      check(rd, 32'h6);
      apb(1'b0, 12'h030, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      check(active_location, LOC_ONE);
      apb(1'b1, `REG_LOC_SELECT, 32'h7);
      settle;
      check({active_location, active_cmd}, {LOC_TWO, 2'b10});
      for (int i = 1; i <= 5; i++) begin
         apb(1'b1, `REG_LOC_SELECT, i);
         di <= ~5'(1 << (i - 1));
         settle;
         check(active_location, LOC_ONE);
         di <= 5'(1 << (i - 1));
         settle;
         check(active_location, LOC_TWO);
      end
      di <= 5'h00;
      apb(1'b1, `REG_LOC_SELECT, 32'h8);
      apb(1'b1, `REG_CONTROL, 32'h6);
      settle;
      check({active_location, ref_is_process}, {LOC_TWO, 1'b1});
      apb(1'b1, `REG_CONTROL, 32'h2);
      settle;
      check({active_location, ref_is_process}, {LOC_ONE, 1'b0});
      apb(1'b1, `REG_CONTROL, 32'h0);
      apb(1'b1, `REG_ONE_LOWER, 32'hA);
      apb(1'b1, `REG_TWO_LOWER, 32'h5);
      apb(1'b1, `REG_TWO_UPPER, 32'h64);
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, `REG_LOC_SELECT, 6 + j);
         for (int k = 0; k < 3; k++) begin
            a1 <= av[k];
            a2 <= av[k];
            settle;
            check(speed_ref, ev[j][k]);
         end
      end
      apb(1'b1, `REG_CONTROL, 32'h1);
      settle;
      check({active_location, speed_ref, ref_is_percent}, {LOC_PANEL, 16'h0123, 1'b0});
      apb(1'b0, `REG_REF_OUT, 32'h0);
      check(rd, 32'h123);
      apb(1'b0, `REG_STATUS, 32'h0);
      check(rd, 32'h5);
      apb(1'b1, `REG_PANEL_UNIT, 32'h2);
      settle;
      check(ref_is_percent, 1'b1);
      apb(1'b1, `REG_CONTROL, 32'h0);
      apb(1'b1, `REG_UPDOWN_STEP, 32'h4000);
      apb(1'b1, `REG_LOC_SELECT, 32'h6);
      apb(1'b1, `REG_ONE_SOURCE, 32'hC);
      press(5'h04);
      check(speed_ref, 16'hFFFF);
      cmds <= 6'h38;
      settle;
      check(speed_ref, 16'hFFFF);
      cmds <= 6'h39;
      apb(1'b1, `REG_TWO_SOURCE, 32'hC);
      apb(1'b1, `REG_LOC_SELECT, 32'h7);
      settle;
      check(speed_ref, 16'h0000);
      apb(1'b1, `REG_LOC_SELECT, 32'h6);
      settle;
      check(speed_ref, 16'hFFFF);
      press(5'h08);
      check(speed_ref, 16'h0000);
      apb(1'b1, `REG_ONE_SOURCE, 32'hB);
      press(5'h04);
      check(speed_ref, 16'hFFFF);
      cmds <= 6'h38;
      settle;
      check(speed_ref, 16'h0000);
      cmds <= 6'h39;
      press(5'h04);
      check(speed_ref, 16'hFFFF);
      apb(1'b1, `REG_CONTROL, 32'h8);
      settle;
      check(speed_ref, 16'h0000);
      apb(1'b1, `REG_CONTROL, 32'h0);
      // location two running, location one stopped: the switch back must not clear two
      apb(1'b1, `REG_TWO_SOURCE, 32'hB);
      apb(1'b1, `REG_LOC_SELECT, 32'h7);
      press(5'h04);
      cmds <= 6'h38;
      apb(1'b1, `REG_LOC_SELECT, 32'h6);
      settle;
      check(speed_ref, 16'h0000);
      apb(1'b1, `REG_LOC_SELECT, 32'h7);
      settle;
      check(speed_ref, 16'hFFFF);
      cmds <= 6'h39;
      apb(1'b1, `REG_LOC_SELECT, 32'h6);
      apb(1'b1, `REG_ONE_SOURCE, 32'hD);
      press(5'h04);
      press(5'h08);
      check(speed_ref, 16'hFFFF);
      press(5'h10);
      check(speed_ref, 16'h0000);
      report_and_stop;
   end
endmodule
